// >>> design/brs_top.sv
// Purpose: backplane receive signaling serial output with frame pulse
// Assumes: backplane clock and frame pulse are pins, sampled twice
// Notes: pin outputs change only on a sampled backplane clock edge, except frame pulse enable, which follows fp_out_mode_i
`timescale 1ns/1ps
`default_nettype none
module brs_top #(
  parameter int FIFO_DEPTH_P = brs_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_i,                         // system clock, 100 MHz
  input wire logic rst_i,                             // async reset, active high
  input wire logic backplane_rx_clock_i,              // backplane clock pin
  input wire logic backplane_rx_frame_pulse_i,        // frame pulse pin, input side
  input wire logic sig_wr_valid_i,                    // signaling update valid
  input wire logic [brs_pkg::CH_W-1:0] sig_wr_channel_i, // channel of update
  input wire logic [brs_pkg::SIG_W-1:0] sig_wr_bits_i,   // new ABCD bits
  output logic sig_wr_ready_o,                        // update accepted
  input wire logic e1_mode_i,                         // 1 = E1, 0 = T1
  input wire logic [1:0] bp_rate_i,                   // backplane clock rate code
  input wire logic fp_out_mode_i,                     // frame pulse is an output
  input wire logic elastic_store_en_i,                // receive elastic store in use
  input wire logic sig_drive_en_i,                    // enable signaling driver
  input wire logic ts_gate_en_i,                      // timeslot-gated mode
  input wire logic [brs_pkg::TS_MAX-1:0] ts_enable_i, // timeslots this device drives
  output logic backplane_rx_signaling_out_o,          // signaling serial data
  output logic backplane_rx_signaling_oe_o,           // signaling driver enable
  output logic backplane_rx_frame_pulse_o,            // frame pulse data
  output logic backplane_rx_frame_pulse_oe_o          // frame pulse driver enable
);
  import brs_pkg::*;

  initial
  begin
    if (FIFO_DEPTH_P < 2)
      $error("brs_top: FIFO_DEPTH_P too small");
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [CNT_W-1:0] frame_len(input logic e1, input logic [1:0] rate);
    logic [CNT_W-1:0] len;
    len = CNT_W'(FRAME_BITS_E1) << rate; // 2048 wraps to 0, so len - 1 still ends the count at 2047
    if (rate == RATE_LINE && !e1)
      len = CNT_W'(FRAME_BITS_T1);
    return len;
  endfunction

  // T1 at line rate carries the framing bit first, ahead of timeslot 0
  function automatic logic [CNT_W-1:0] slot_offset(input logic [CNT_W-1:0] pos, input logic e1,
                                                   input logic [1:0] rate);
    logic [CNT_W-1:0] off;
    off = pos;
    if (rate == RATE_LINE && !e1)
      off = pos - 11'h001;
    return off;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic bit_en;
  logic fp_lvl;

  brs_sync u_clk_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(backplane_rx_clock_i),
    .lvl_o(),
    .rise_o(bit_en)
  );

  brs_sync u_fp_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(backplane_rx_frame_pulse_i),
    .lvl_o(fp_lvl),
    .rise_o()
  );

  ////////////////////////////////////////////////////////////////////////
  // update buffer, drained one word per backplane bit

  logic fifo_valid;
  logic [FIFO_W-1:0] fifo_data;
  logic pop;

  // drain rate is tied to the backplane clock, so bursts back up here
  brs_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH_P)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(sig_wr_valid_i),
    .in_data_i({sig_wr_channel_i, sig_wr_bits_i}),
    .in_ready_o(sig_wr_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(bit_en)
  );

  assign pop = fifo_valid && bit_en;

  ////////////////////////////////////////////////////////////////////////
  // per-channel signaling table

  logic [SIG_W-1:0] table_reg [CHANNELS_E1];
  logic [SIG_W-1:0] table_next [CHANNELS_E1];

  // values persist until updated, so each frame repeats them
  always_comb
  begin
    table_next = table_reg;
    if (pop)
      table_next[fifo_data[FIFO_W-1:SIG_W]] = fifo_data[SIG_W-1:0];
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < CHANNELS_E1; i++)
        table_reg[i] <= SIG_RESET;
    end
    else
    begin
      table_reg <= table_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame position and serial output

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic fp_prev_reg;
  logic fp_prev_next;
  logic sig_reg;
  logic sig_next;
  logic oe_reg;
  logic oe_next;
  logic fpo_reg;
  logic fpo_next;
  logic fpoe_reg;
  logic fpoe_next;
  logic align;
  logic [CNT_W-1:0] pos;
  logic [CNT_W-1:0] off;
  logic [TS_W-1:0] ts;
  logic [2:0] bitpos;
  logic [CH_W-1:0] ch;
  logic in_slot;
  logic ch_ok;
  logic sig_pos;
  logic ts_sel;
  logic [SIG_W-1:0] cur_bits;

  always_comb
  begin
    // wide input pulses align once, on their leading edge only
    align = bit_en && !fp_out_mode_i && elastic_store_en_i && fp_lvl && !fp_prev_reg;
    pos = align ? '0 : cnt_reg;
    off = slot_offset(pos, e1_mode_i, bp_rate_i);
    in_slot = !(bp_rate_i == RATE_LINE && !e1_mode_i && pos == '0);
    ts = off[CNT_W-1:3];
    bitpos = off[2:0];
    // byte interleave: each channel owns a run of 2^rate timeslots
    ch = CH_W'(ts >> bp_rate_i);
    ch_ok = e1_mode_i ? 1'b1 : (ch < CH_W'(CHANNELS_T1));
    sig_pos = in_slot && ch_ok && bitpos >= SIG_FIRST_POS;
    cur_bits = table_reg[ch];
    ts_sel = ts_enable_i[ts];

    cnt_next = cnt_reg;
    fp_prev_next = fp_prev_reg;
    sig_next = sig_reg;
    oe_next = oe_reg;
    fpo_next = fpo_reg;
    fpoe_next = fp_out_mode_i;
    if (bit_en)
    begin
      fp_prev_next = fp_lvl;
      cnt_next = (pos == frame_len(e1_mode_i, bp_rate_i) - 11'h001) ? '0 : pos + 11'h001;
      sig_next = sig_pos ? cur_bits[~bitpos[1:0]] : IDLE_BIT;
      oe_next = sig_drive_en_i;
      if (ts_gate_en_i && bp_rate_i != RATE_LINE)
        oe_next = sig_drive_en_i && in_slot && ts_sel;
      fpo_next = fp_out_mode_i && pos == '0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= '0;
      fp_prev_reg <= 1'b0;
      sig_reg <= IDLE_BIT;
      oe_reg <= 1'b0;
      fpo_reg <= 1'b0;
      fpoe_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      fp_prev_reg <= fp_prev_next;
      sig_reg <= sig_next;
      oe_reg <= oe_next;
      fpo_reg <= fpo_next;
      fpoe_reg <= fpoe_next;
    end
  end

  assign backplane_rx_signaling_out_o = sig_reg;
  assign backplane_rx_signaling_oe_o = oe_reg;
  assign backplane_rx_frame_pulse_o = fpo_reg;
  assign backplane_rx_frame_pulse_oe_o = fpoe_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  logic exp_bit;
  assign exp_bit = cur_bits[~bitpos[1:0]];

  property p_sig_bits;
    (bit_en && sig_pos) |=> (backplane_rx_signaling_out_o == $past(exp_bit));
  endproperty
  a_sig_bits: assert property (p_sig_bits) else $error("signaling bit wrong");

  property p_idle_bits;
    (bit_en && !sig_pos) |=> (backplane_rx_signaling_out_o == IDLE_BIT);
  endproperty
  a_idle_bits: assert property (p_idle_bits) else $error("non-signaling bit not idle");

  property p_repeat;
    (bit_en && sig_pos && !pop) ##1 !pop [*2] |-> (table_reg[$past(ch, 2)] == $past(cur_bits, 2));
  endproperty
  a_repeat: assert property (p_repeat) else $error("signaling value lost between frames");

  property p_wrap;
    (bit_en && pos == frame_len(e1_mode_i, bp_rate_i) - 11'h001) |=> (cnt_reg == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("frame length wrong");

  property p_align;
    align |=> (cnt_reg == 11'h001);
  endproperty
  a_align: assert property (p_align) else $error("not aligned to input frame pulse");

  property p_line_rate_drive;
    (bit_en && sig_drive_en_i && bp_rate_i == RATE_LINE) |=> backplane_rx_signaling_oe_o;
  endproperty
  a_line_rate_drive: assert property (p_line_rate_drive) else $error("gated at line rate");

  property p_hiz_off;
    (bit_en && !sig_drive_en_i) |=> !backplane_rx_signaling_oe_o;
  endproperty
  a_hiz_off: assert property (p_hiz_off) else $error("driving while disabled");

  property p_edge_only;
    !bit_en |=> ($stable(backplane_rx_signaling_out_o) && $stable(backplane_rx_signaling_oe_o)
                 && $stable(backplane_rx_frame_pulse_o));
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("output changed off clock edge");

  property p_fp_t1;
    (bit_en && fp_out_mode_i && !e1_mode_i && bp_rate_i == RATE_LINE && cnt_reg == CNT_W'(FRAME_BITS_T1 - 1))
      |=> (cnt_reg == '0) ##0 (!backplane_rx_frame_pulse_o);
  endproperty
  a_fp_t1: assert property (p_fp_t1) else $error("T1 frame not 193 bits");

  property p_fp_bit1;
    (bit_en && fp_out_mode_i && !align) |=> (backplane_rx_frame_pulse_o == ($past(cnt_reg) == '0));
  endproperty
  a_fp_bit1: assert property (p_fp_bit1) else $error("frame pulse not at bit 1");

  property p_fp_e1;
    (bit_en && fp_out_mode_i && e1_mode_i && bp_rate_i == RATE_LINE && cnt_reg == CNT_W'(FRAME_BITS_E1 - 1))
      |=> (cnt_reg == '0);
  endproperty
  a_fp_e1: assert property (p_fp_e1) else $error("E1 frame not 256 bits");

  property p_gate;
    (bit_en && ts_gate_en_i && bp_rate_i != RATE_LINE && !ts_sel) |=> !backplane_rx_signaling_oe_o;
  endproperty
  a_gate: assert property (p_gate) else $error("driving unselected timeslot");

  property p_cov_align;
    align;
  endproperty
  c_align: cover property (p_cov_align);

  property p_cov_gate;
    ts_gate_en_i && $rose(backplane_rx_signaling_oe_o);
  endproperty
  c_gate: cover property (p_cov_gate);

  property p_cov_full;
    !sig_wr_ready_o && sig_wr_valid_i;
  endproperty
  c_full: cover property (p_cov_full);

  property p_cov_fp;
    $rose(backplane_rx_frame_pulse_o);
  endproperty
  c_fp: cover property (p_cov_fp);
endmodule
`default_nettype wire

// >>> design/brs_pkg.sv
// Purpose: shared constants for the backplane receive signaling output
// Assumes: one system clock, backplane clock sampled as a plain input
// Notes: timeslot and bit positions count from zero inside the design
package brs_pkg;
  localparam int FRAME_BITS_T1 = 193;
  localparam int FRAME_BITS_E1 = 256;
  localparam int CHANNELS_T1 = 24;
  localparam int CHANNELS_E1 = 32;
  localparam int TS_MAX = 256;
  localparam int CNT_W = 11;
  localparam int TS_W = 8;
  localparam int CH_W = 5;
  localparam int SIG_W = 4;
  // bit 5 of a timeslot is position 4 when counting from zero
  localparam logic [2:0] SIG_FIRST_POS = 3'h4;
  localparam logic IDLE_BIT = 1'b1;
  localparam logic [SIG_W-1:0] SIG_RESET = 4'h0;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = CH_W + SIG_W;
  // backplane clock rate codes: line rate, 4.096, 8.192, 16.384 MHz
  localparam logic [1:0] RATE_LINE = 2'h0;
  localparam logic [1:0] RATE_4M = 2'h1;
  localparam logic [1:0] RATE_8M = 2'h2;
  localparam logic [1:0] RATE_16M = 2'h3;
  localparam int SYNC_STAGES = 2;
endpackage

// >>> design/brs_sync.sv
// Purpose: two-stage synchroniser with rising-edge detect
// Assumes: input comes from outside the system clock domain
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module brs_sync (
  input wire logic clk_sys_i, // system clock
  input wire logic rst_i,     // async reset, active high
  input wire logic async_i,   // asynchronous level
  output logic lvl_o,         // synchronised level
  output logic rise_o         // one-cycle pulse on rising edge
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;
  logic prev_reg;
  logic prev_next;

  always_comb
  begin
    meta_next = async_i;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign lvl_o = sync_reg;
  assign rise_o = sync_reg & ~prev_reg;
endmodule
`default_nettype wire

// >>> design/brs_fifo.sv
// Purpose: small synchronous FIFO for signaling updates
// Assumes: one clock; push and pop may coincide
// Notes: in_ready_o is registered so it can leave the block directly
`timescale 1ns/1ps
`default_nettype none
module brs_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_i,          // system clock
  input wire logic rst_i,              // async reset, active high
  input wire logic in_valid_i,         // write request
  input wire logic [WIDTH-1:0] in_data_i, // write data
  output logic in_ready_o,             // room available
  output logic out_valid_o,            // data available
  output logic [WIDTH-1:0] out_data_o, // head word
  input wire logic out_ready_i         // drain side takes head
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("brs_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] wr_next;
  logic [AW-1:0] rd_reg;
  logic [AW-1:0] rd_next;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic rdy_reg;
  logic rdy_next;
  logic push;
  logic pop;

  always_comb
  begin
    push = in_valid_i && rdy_reg;
    pop = out_valid_o && out_ready_i;
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    rdy_next = cnt_next != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
  end

  // storage has no reset; only words behind the count are ever read
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data_i;
  end

  assign in_ready_o = rdy_reg;
  assign out_valid_o = cnt_reg != '0;
  assign out_data_o = mem_reg[rd_reg];
endmodule
`default_nettype wire

// >>> testbench/brs_bp_model.sv
// Purpose: backplane timing partner for the signaling output
// Assumes: backplane clock well below a quarter of the system clock
// Notes: each bit is read just before the next rising edge
`timescale 1ns/1ps
`default_nettype none
module brs_bp_model #(
  parameter int HALF_NS = 30
) (
  input wire logic run_i,         // clock runs when high
  input wire logic fp_en_i,       // drive frame pulse
  input wire logic [11:0] flen_i, // bits per frame
  input wire logic sig_i,         // signaling line
  input wire logic oe_i,          // signaling enable
  input wire logic fp_line_i,     // frame pulse line
  output logic bp_clk_o,          // backplane clock
  output logic fp_o,              // frame pulse drive
  output logic [11:0] pos_o,      // position of sampled bit
  output logic dat_o,             // sampled data
  output logic oe_o,              // sampled enable
  output logic fps_o              // sampled frame pulse
);
  logic [11:0] cur = 12'h0;
  initial
  begin
    bp_clk_o = 1'b0;
    forever
    begin
      #HALF_NS;
      if (run_i)
        bp_clk_o = ~bp_clk_o;
    end
  end
  ////////////////////////////////////////
  // output of the previous edge has settled a full bit later
  always @(posedge bp_clk_o)
  begin
    pos_o <= cur;
    dat_o <= oe_i ? sig_i : ~sig_i; // released line reads as the inverse
    oe_o <= oe_i;
    fps_o <= fp_line_i;
    cur <= (cur >= flen_i - 12'h1) ? 12'h0 : cur + 12'h1;
  end
  always @(negedge bp_clk_o)
    fp_o <= fp_en_i && (cur >= flen_i - 12'h1);
endmodule
`default_nettype wire

// >>> testbench/tb_brs_top.sv
// Purpose: self-checking bench for the signaling output block
// Assumes: partner model makes backplane clock, and frame pulse unless fp_out hands it to the design
// Notes: expected bits come from a shadow signaling table
`timescale 1ns/1ps
`default_nettype none
module tb_brs_top;
  import brs_pkg::*;
  typedef struct packed {logic oe; logic dat;} brs_exp_t;
  logic clk_sys_i, rst_i, wr_valid, e1, fp_out, es_en, drv_en, gate, run, fp_en;
  logic [CH_W-1:0] wr_ch;
  logic [SIG_W-1:0] wr_bits;
  logic [1:0] rate;
  logic [TS_MAX-1:0] mask;
  logic [11:0] flen;
  wire logic bp_clk, fp_model, wr_ready, sig, sig_oe, fp_dut, fp_oe, fp_line, m_dat, m_oe, m_fp;
  wire logic [11:0] m_pos;
  logic [3:0] tbl [CHANNELS_E1];
  brs_exp_t exp_q [$];
  int n_mismatch = 0, check_count = 0, seed, dev, stalls = 0;
  int arm = 0, started = 0, fp_chk = 0, fp_gap = 0, fp_hits = 0;
  assign fp_line = fp_oe ? fp_dut : fp_model;
  brs_top brs_top_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .backplane_rx_clock_i(bp_clk),
    .backplane_rx_frame_pulse_i(fp_line), .sig_wr_valid_i(wr_valid), .sig_wr_channel_i(wr_ch),
    .sig_wr_bits_i(wr_bits), .sig_wr_ready_o(wr_ready), .e1_mode_i(e1), .bp_rate_i(rate),
    .fp_out_mode_i(fp_out), .elastic_store_en_i(es_en), .sig_drive_en_i(drv_en),
    .ts_gate_en_i(gate), .ts_enable_i(mask), .backplane_rx_signaling_out_o(sig),
    .backplane_rx_signaling_oe_o(sig_oe), .backplane_rx_frame_pulse_o(fp_dut),
    .backplane_rx_frame_pulse_oe_o(fp_oe));
  brs_bp_model brs_bp_model_i (.run_i(run), .fp_en_i(fp_en), .flen_i(flen), .sig_i(sig),
    .oe_i(sig_oe), .fp_line_i(fp_line), .bp_clk_o(bp_clk), .fp_o(fp_model), .pos_o(m_pos),
    .dat_o(m_dat), .oe_o(m_oe), .fps_o(m_fp));
  ////////////////////////////////////////
  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    check_count++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // valid stays up on return so back-to-back words need no gap
  task automatic push(input logic [CH_W-1:0] ch, input logic [SIG_W-1:0] b);
    int k;
    k = 0;
    wr_valid <= 1'b1;
    wr_ch <= ch;
    wr_bits <= b;
    @(posedge clk_sys_i);
    while (wr_ready !== 1'b1 && k < 5000)
    begin
      k++;
      @(posedge clk_sys_i);
    end
    stalls += k;
    check(k < 5000, 1'b1);
    tbl[ch] = b;
  endtask
  function automatic brs_exp_t exp_bit(input int p);
    int q;
    brs_exp_t e;
    q = e1 ? p : p - 1;
    e.oe = drv_en && (rate == RATE_LINE || !gate || (q >= 0 && mask[q >> 3]));
    e.dat = IDLE_BIT;
    if (q >= 0 && q[2])
      e.dat = tbl[(q >> 3) >> rate][3 - q[1:0]];
    return e;
  endfunction
  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 40000)
    begin
      @(negedge bp_clk);
      k++;
      if (m_pos == flen - 12'h1)
        n--;
    end
    check(n == 0, 1'b1);
  endtask
  task automatic check_frames(input int nf);
    int k;
    k = 0;
    wait_frames(1);
    for (int f = 0; f < nf; f++)
      for (int p = 0; p < flen; p++)
        exp_q.push_back(exp_bit(p));
    arm = 1;
    while (exp_q.size() > 0 && k < 40000)
    begin
      @(negedge bp_clk);
      k++;
    end
    arm = 0;
    check(exp_q.size(), 0);
    exp_q.delete();
  endtask
  ////////////////////////////////////////
  initial
  begin
    clk_sys_i = 1'b0;
    forever
      #5 clk_sys_i = ~clk_sys_i;
  end
  always @(negedge bp_clk)
  begin
    if (arm == 0)
      started = 0;
    else if ((started != 0 || m_pos == 12'h0) && exp_q.size() > 0)
    begin
      brs_exp_t e;
      started = 1;
      e = exp_q.pop_front();
      check(m_oe, e.oe);
      if (e.oe)
        check(m_dat, e.dat);
    end
    if (fp_chk != 0 && m_fp === 1'b1)
    begin
      if (fp_hits > 0)
        check(fp_gap, flen);
      fp_hits++;
      fp_gap = 0;
    end
    fp_gap++;
  end
  initial
  begin
    #1000000;
    n_mismatch++;
    final_report();
  end
  initial
  begin
    seed = 32'h3107;
    {rst_i, run, fp_en, e1, es_en} = 5'h1f;
    {wr_valid, fp_out, drv_en, gate} = 4'h0;
    wr_ch = '0;
    wr_bits = '0;
    rate = RATE_LINE;
    mask = '0;
    flen = 12'd256;
    foreach (tbl[i])
      tbl[i] = SIG_RESET;
    repeat (12) @(posedge clk_sys_i);
    check(wr_ready, 1'b0);
    check(sig_oe, 1'b0);
    check(fp_oe, 1'b0);
    rst_i <= 1'b0;
    check_frames(1);
    @(posedge clk_sys_i);
    drv_en <= 1'b1;
    run <= 1'b0;
    // gating requested at line rate must be ignored
    gate <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    for (int i = 0; i < FIFO_DEPTH; i++)
      push(CH_W'(i), SIG_W'($random(seed)));
    check(stalls, 0);
    repeat (8)
    begin
      @(posedge clk_sys_i);
      check(wr_ready, 1'b0);
    end
    run <= 1'b1;
    for (int i = 16; i < 40; i++)
      push(CH_W'(i < 32 ? i : $random(seed)), SIG_W'($random(seed)));
    wr_valid <= 1'b0;
    // let queued updates drain into the table before any frame is checked
    wait_frames(1);
    for (int m = 1; m >= 0; m--)
    begin
      @(posedge clk_sys_i);
      e1 <= m[0];
      flen <= m[0] ? 12'd256 : 12'd193;
      check_frames(2);
    end
    dev = $random(seed) & 3;
    for (int r = 1; r < 4; r++)
    begin
      @(posedge clk_sys_i);
      e1 <= 1'b1;
      rate <= r[1:0];
      gate <= 1'b1;
      flen <= 12'd256 << r;
      for (int n = 0; n < TS_MAX; n++)
        mask[n] <= (n % 4) == dev;
      check_frames(1);
    end
    @(posedge clk_sys_i);
    {gate, es_en, fp_en, fp_out} <= 4'h1;
    rate <= RATE_LINE;
    for (int m = 1; m >= 0; m--)
    begin
      @(posedge clk_sys_i);
      e1 <= m[0];
      flen <= m[0] ? 12'd256 : 12'd193;
      wait_frames(2);
      fp_hits = 0;
      fp_chk = 1;
      wait_frames(4);
      fp_chk = 0;
      check(fp_hits > 2, 1'b1);
      check(fp_oe, 1'b1);
    end
    final_report();
  end
endmodule
`default_nettype wire
